/* src/eer_pkg.sv */
// Package for the serial memory read path: widths, codes, states.
// Assumes one system clock; bus pins are sampled synchronously.
package eer_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_TOP = 12'hfff;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic DIR_READ = 1'b1;

  // Bus pin pair as sampled
  typedef struct packed {
    logic scl;
    logic sda;
  } eer_pins_t;

  // Memory read port
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } eer_mem_t;

  typedef enum logic [2:0] {
    EER_IDLE = 3'b000,
    EER_DEVADR = 3'b001,
    EER_ACK = 3'b011,
    EER_ADRHI = 3'b010,
    EER_ADRLO = 3'b110,
    EER_TX = 3'b111,
    EER_MACK = 3'b101,
    EER_WAIT = 3'b100
  } eer_state_t;
endpackage

/* src/eer_read_path.sv */
// Slave read path of a serial memory: address counter and read forms.
// Assumes SCL/SDA sampled on sys_clk_i, memory data valid one clock after address.
//
// Behaviour
// R1 - After access to address N the counter points to N plus one.
// R2 - Counter rolls from 4095 to zero and keeps reading.
// R3 - Matching read address is acknowledged, then the current byte shifts out.
// R4 - Master ends a single read with no acknowledge then STOP.
// R5 - Random read starts with a dummy write of the byte address.
// R6 - Master then issues repeated START and read-direction address.
// R7 - After repeated START the byte at the loaded address is sent.
// R8 - Sequential read begins from current or random read.
// R9 - Master acknowledges bytes it wants and ends with STOP.
// R10 - Each master acknowledge causes another byte from the next address.
// R11 - Every counter bit increments so the whole array is readable.
// R12 - Address byte LSB one selects read, zero selects write.
// R13 - Without master acknowledge the device releases SDA, waits for STOP.
// R14 - Dummy write address comes as two acknowledged bytes.
// R15 - During a programming cycle no request is answered.
// R16 - Twelve-bit counter advances after each transmitted byte.
// R17 - Counter loads right after the second address byte acknowledge; the code loads it at the SCL fall ending that byte, as the acknowledge starts.
`timescale 1ns/100ps
module eer_read_path
  import eer_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire eer_pins_t pins_i,
  input wire logic prog_busy_i,
  input wire logic [7:0] mem_data_i,
  output logic [11:0] mem_addr_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [11:0] addr_cnt_o
);
  eer_state_t state;
  eer_pins_t pins_q;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [11:0] addr_cnt;
  logic [3:0] adr_hi;
  logic got_byte;
  eer_state_t ack_ret;
  logic ack_next;
  logic sda_oe;

  wire scl_rise = pins_i.scl & ~pins_q.scl;
  wire scl_fall = ~pins_i.scl & pins_q.scl;
  wire start_c = pins_i.scl & pins_q.scl & pins_q.sda & ~pins_i.sda;
  wire stop_c = pins_i.scl & pins_q.scl & ~pins_q.sda & pins_i.sda;

  // Next counter value; ADDR_TOP wraps explicitly to ADDR_RST
  function automatic logic [11:0] incr(input logic [11:0] a);
    return (a == ADDR_TOP) ? ADDR_RST : a + 12'h001;
  endfunction

  // ****************************************
  // Pin history for edge and condition detection
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      pins_q <= pins_i;
    end
  end

  // ****************************************
  // Protocol sequencer
  // ****************************************
  // Start/stop take priority over any bit activity
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= EER_IDLE;
      ack_ret <= EER_WAIT;
      bit_cnt <= 3'h0;
      got_byte <= 1'b0;
      shreg <= 8'h00;
      ack_next <= 1'b0;
      adr_hi <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= EER_IDLE;
      got_byte <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state <= prog_busy_i ? EER_IDLE : EER_DEVADR; // R15
      bit_cnt <= 3'h0;
      got_byte <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        EER_IDLE, EER_WAIT: begin
          sda_oe <= 1'b0;
        end
        // The SCL fall right after a START also sees bit_cnt at zero,
        // so a flag marks a complete byte rather than the count alone
        EER_DEVADR, EER_ADRHI, EER_ADRLO: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], pins_i.sda};
            bit_cnt <= bit_cnt + 3'h1;
            got_byte <= (bit_cnt == BIT_LAST);
          end else if (scl_fall && got_byte) begin
            got_byte <= 1'b0;
            ack_next <= 1'b0;
            sda_oe <= 1'b1; // R14
            state <= EER_ACK;
            if (state == EER_DEVADR) begin
              ack_next <= (shreg[0] == DIR_READ); // R3 R12
              ack_ret <= EER_ADRHI;
              if (shreg[7:4] != DEV_CODE) begin
                sda_oe <= 1'b0; // Foreign code: silent until STOP or START
                state <= EER_WAIT;
              end
            end else if (state == EER_ADRHI) begin
              adr_hi <= shreg[3:0]; // R14
              ack_ret <= EER_ADRLO;
            end else begin
              ack_ret <= EER_WAIT; // Data bytes belong to the write path
            end
          end
        end
        EER_ACK: begin
          // Ack held low until SCL falls after the ninth pulse
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (ack_next) begin
              shreg <= mem_data_i; // R3 R7
              sda_oe <= ~mem_data_i[7];
              state <= EER_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= ack_ret;
            end
          end
        end
        EER_TX: begin
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              sda_oe <= 1'b0; // Release for master acknowledge
              state <= EER_MACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        EER_MACK: begin
          if (scl_rise) begin
            // No acknowledge: stay off the line until STOP or START
            state <= pins_i.sda ? EER_WAIT : EER_ACK; // R13
            ack_next <= ~pins_i.sda; // R10
          end
        end
      endcase
    end
  end

  // ****************************************
  // Address counter
  // ****************************************
  // Ack state also re-entered on master ack; the mem fetch happens at that fall
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_cnt <= ADDR_RST;
    end else if (!stop_c && !start_c && state == EER_ADRLO && scl_fall && got_byte) begin
      addr_cnt <= {adr_hi, shreg}; // R17
    end else if (!stop_c && !start_c && state == EER_TX && scl_fall && bit_cnt == BIT_LAST) begin
      addr_cnt <= incr(addr_cnt); // R1 R2 R11 R16
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_addr_o <= ADDR_RST;
      sda_o <= 1'b1;
      sda_oe_o <= 1'b0;
      addr_cnt_o <= ADDR_RST;
    end else begin
      mem_addr_o <= addr_cnt; // R8
      sda_o <= 1'b0; // Open drain: only ever pulls low
      sda_oe_o <= sda_oe;
      addr_cnt_o <= addr_cnt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_wrap_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R2
    (state == EER_TX && scl_fall && bit_cnt == BIT_LAST && !start_c && !stop_c
     && addr_cnt == ADDR_TOP) |=> addr_cnt == ADDR_RST)
    else $error("counter did not wrap to zero");
  chk_incr_byte: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R1
    (state == EER_TX && scl_fall && bit_cnt == BIT_LAST && !start_c && !stop_c)
    |=> addr_cnt == incr($past(addr_cnt)))
    else $error("counter did not advance after byte");
  chk_nack_release: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R13
    (state == EER_MACK && scl_rise && pins_i.sda && !start_c && !stop_c)
    |=> state == EER_WAIT ##1 !sda_oe_o)
    else $error("line not released after no acknowledge");
  chk_busy_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R15
    (start_c && prog_busy_i && !stop_c) |=> state == EER_IDLE)
    else $error("request answered while busy");
  chk_load_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R17
    (state == EER_ADRLO && scl_fall && got_byte && !start_c && !stop_c)
    |=> addr_cnt == {$past(adr_hi), $past(shreg)})
    else $error("address not loaded after second byte");
  // A matching address must pull SDA low two clocks after the eighth fall
  chk_addr_ack: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R3
    (state == EER_DEVADR && scl_fall && got_byte && shreg[7:4] == DEV_CODE
     && !start_c && !stop_c) |=> ##1 sda_oe_o)
    else $error("matching address not acknowledged");
endmodule // eer_read_path

/* test/eer_bm.sv */
// I2C bus master model that drives the read path from the far side.
// Assumes the bench wires SDA open drain with a pull-up.
`timescale 1ns/100ps
module eer_bm (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  // ******************
  // Bus phases
  // ******************
  // Idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Four clocks a phase, above the three-clock floor
  task automatic hold();
    repeat (4) @(posedge clk_i);
  endtask

  // START; from a low clock it is a repeated START
  task automatic start();
    pull_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    pull_o <= 1'b1;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask

  // STOP ends every transfer, also after a withheld acknowledge
  task automatic stop();
    pull_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    pull_o <= 1'b0;
    hold();
  endtask

  // One clock pulse; sample mid-high, away from edges
  task automatic clk_bit(input logic pull_v, output logic s);
    pull_o <= pull_v;
    hold();
    scl_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) s = sda_i;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b0;
    hold();
  endtask

  // Byte to the device, MSB first, then its acknowledge
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
  endtask

  // Byte from the device; acknowledge only when more is wanted
  task automatic byte_rx(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, d[i]);
    clk_bit(more, s);
  endtask
endmodule // eer_bm

/* test/tb_top.sv */
// Self-checking bench for the read path, master model on the bus.
// Assumes memory data one clock behind the address.
`timescale 1ns/100ps
module tb_top;
  import eer_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic prog_busy = 1'b0;
  logic [7:0] mem_data = 8'h00;
  logic [11:0] mem_addr;
  logic [11:0] addr_cnt;
  logic sda_o, sda_oe, scl, pull, sda;
  eer_pins_t pins;
  int num_errors = 0;
  int cmp_count = 0;

  // ******************
  // Harness
  // ******************
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction

  always #20 sys_clk = ~sys_clk;
  // Open-drain line: either party pulls low
  assign sda = ~(pull | (sda_oe & ~sda_o));
  assign pins = '{scl: scl, sda: sda};
  always @(posedge sys_clk) mem_data <= pat(mem_addr);

  eer_read_path i_eer_read_path (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .pins_i(pins),
    .prog_busy_i(prog_busy), .mem_data_i(mem_data), .mem_addr_o(mem_addr),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_cnt_o(addr_cnt));
  eer_bm i_eer_bm (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ******************
  // Transfers
  // ******************
  task automatic dev_sel(input logic dir, input logic exp_ack);
    logic ack;
    i_eer_bm.start();
    i_eer_bm.byte_tx({DEV_CODE, 3'h0, dir}, ack);
    cmp({11'h0, ack}, {11'h0, exp_ack});
  endtask

  // Reads n bytes from a, refuses the last, checks release and counter
  task automatic read_bytes(input logic [11:0] a, input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      i_eer_bm.byte_rx(k < n - 1, d);
      cmp({4'h0, d}, {4'h0, pat(a + 12'(k))});
    end
    i_eer_bm.stop();
    cmp({11'h0, sda_oe}, 12'h000);
    cmp(addr_cnt, a + 12'(n));
  endtask

  task automatic rand_read(input logic [11:0] a, input int n);
    logic ack;
    dev_sel(1'b0, 1'b1);
    i_eer_bm.byte_tx({4'h0, a[11:8]}, ack);
    cmp({11'h0, ack}, 12'h001);
    i_eer_bm.byte_tx(a[7:0], ack);
    cmp({11'h0, ack}, 12'h001);
    cmp(addr_cnt, a);
    dev_sel(1'b1, 1'b1);
    read_bytes(a, n);
  endtask

  // ******************
  // Scenarios
  // ******************
  task automatic t_random_seq();
    rand_read(12'h123, 4);
  endtask

  task automatic t_current();
    dev_sel(1'b1, 1'b1);
    read_bytes(12'h127, 1);
  endtask

  task automatic t_wrap();
    rand_read(12'hffe, 3);
  endtask

  // Foreign code and busy programming are both ignored
  task automatic t_refuse();
    logic ack;
    i_eer_bm.start();
    i_eer_bm.byte_tx(8'h5b, ack);
    cmp({11'h0, ack}, 12'h000);
    i_eer_bm.stop();
    prog_busy <= 1'b1;
    dev_sel(1'b1, 1'b0);
    i_eer_bm.stop();
    prog_busy <= 1'b0;
    dev_sel(1'b1, 1'b1);
    read_bytes(12'h001, 1);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_random_seq();
    t_current();
    t_wrap();
    t_refuse();
    give_verdict();
  end

  // Whole run needs about 2500 clocks
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
